// File: logic/adc_seq_defines.svh
// constants for the converter control sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// master clock divide to modulator rate (64 x fs)
`define DIV_256_MODE      3'h4
`define DIV_384_MODE      3'h6
// bit slots per stereo frame at the modulator rate
`define BITS_PER_FRAME    7'h40
`define SLOT_LAST         6'h3f
// filter group delay in output word periods
`define GROUP_DELAY_WORDS 36
// offset calibration length in frame periods
`define CAL_FRAMES        8192
// level tag codes
`define LVL_UNDER_MORE    2'h0
`define LVL_UNDER_NEAR    2'h1
`define LVL_OVER_NEAR     2'h2
`define LVL_OVER_MORE     2'h3
// magnitude 1 dB under full scale
`define NEAR_FS_THRESH    16'h7214
// output buffer depth in words
`define OUT_FIFO_DEPTH    8

`endif

// File: logic/adc_seq_pkg.sv
// types shared by the converter control sequencer
`default_nettype none

package adc_seq_pkg;

    // start-up sequence states, one-hot
    typedef enum logic [5:0] {
        ST_RESET     = 6'h01,
        ST_SYNC      = 6'h02,
        ST_WAIT_FALL = 6'h04,
        ST_WAIT_RISE = 6'h08,
        ST_CAL       = 6'h10,
        ST_RUN       = 6'h20
    } seq_state_type;

endpackage : adc_seq_pkg

`default_nettype wire

// File: logic/audio_adc_control_sequencer.sv
// control and sequencing of a stereo sigma-delta audio converter
`include "adc_seq_defines.svh"
`default_nettype none

// Function
// RQ1 - output lags input by 36 word periods
// RQ2 - ratio pin selects 384 or 256 clock
// RQ3 - divide to 64 fs, words at fs
// RQ4 - master mode derives serial clocks internally
// RQ5 - slave clocks share master clock source
// RQ6 - reset clears filter state and buffer
// RQ7 - reset drives outputs low, bit clock idles
// RQ8 - reset release on falling clock edge
// RQ9 - shared reset devices start sampling together
// RQ10 - slave waits frame fall then rise
// RQ11 - word clock mode needs word clock high
// RQ12 - calibration lasts 8192 frames after reset
// RQ13 - slave calibration counts from first rise
// RQ14 - reset held means power-down, then calibrate
// RQ15 - level tag two bits per sample
// RQ16 - level tag encodes four levels near full
// RQ17 - two's complement msb first, left first
// RQ18 - reset release synchronised before sequencing
module audio_adc_control_sequencer #(
    parameter int CAL_FRAMES  = `CAL_FRAMES,
    parameter int DELAY_WORDS = `GROUP_DELAY_WORDS,
    parameter int FIFO_DEPTH  = `OUT_FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ratio_384_sel,
    input  wire logic        slave_mode,
    input  wire logic        word_clock_in_mode,
    input  wire logic        bit_clock_edge_select,
    input  wire logic        channel_frame_clock_in,
    input  wire logic        word_clock_in,
    input  wire logic        sample_in_valid,
    output logic             sample_in_ready,
    input  wire logic [15:0] sample_in_left,
    input  wire logic [15:0] sample_in_right,
    input  wire logic        over_fs_near,
    input  wire logic        over_fs_more,
    output logic             modulator_tick,
    output logic             serial_bit_clock,
    output logic             channel_frame_clock,
    output logic             serial_data_output,
    output logic             level_tag_output,
    output logic             calibrating,
    output logic             sampling
);
    // counters must hold their limits
    initial
    begin
        if (CAL_FRAMES < 1 || CAL_FRAMES > 65535 || DELAY_WORDS < 1 ||
            DELAY_WORDS > 255 || FIFO_DEPTH < 2)
            $error("audio_adc_control_sequencer: bad parameter");
    end

    // ************************************************
    // clock ratio divider and frame slot counter
    // ************************************************
    logic [2:0] div_r;       // master clock phase in a modulator bit
    logic [2:0] div_nxt;
    logic [5:0] slot_r;      // bit slot inside the 64-slot frame
    logic [5:0] slot_nxt;
    logic [2:0] div_len;     // master clocks per modulator bit
    logic       bclk_r;      // internal bit clock, high half first
    logic       bclk_nxt;
    logic       frame_r;     // master frame clock, high for left
    logic       frame_nxt;
    logic       fr_prev_r;   // last sampled external frame clock
    logic       fr_rise;
    logic       fr_fall;
    logic       word_tick;   // one pulse per output word period
    logic       running;     // sequencer past the start-up gate

    // RQ2 ratio pin picks divide
    assign div_len = ratio_384_sel ? `DIV_384_MODE : `DIV_256_MODE;
    // RQ3 modulator rate enable
    assign modulator_tick = running && (div_r == div_len - 3'h1);
    assign fr_rise = channel_frame_clock_in && !fr_prev_r;
    assign fr_fall = !channel_frame_clock_in && fr_prev_r;
    // slave frames come from outside, master frames from the counter
    assign word_tick = slave_mode ? (running && fr_rise)
                     : (modulator_tick && slot_r == `SLOT_LAST);

    // divider and slot next values
    always_comb
    begin
        div_nxt   = div_r;
        slot_nxt  = slot_r;
        bclk_nxt  = bclk_r;
        frame_nxt = frame_r;
        if (!running)
        begin
            // held static until the start-up gate opens
            div_nxt   = 3'h0;
            slot_nxt  = 6'h00;
            bclk_nxt  = 1'b0;
            frame_nxt = 1'b0;
        end
        else
        begin
            div_nxt = modulator_tick ? 3'h0 : div_r + 3'h1;
            if (slave_mode && fr_rise)
                // re-align the slot count to the host frame
                slot_nxt = 6'h00;
            else if (modulator_tick)
                slot_nxt = slot_r + 6'h01;
            // RQ4 serial clocks from divider
            bclk_nxt  = (div_nxt < {1'b0, div_len[2:1]});
            frame_nxt = !slot_nxt[5];
        end
    end

    // divider registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            div_r     <= 3'h0;
            slot_r    <= 6'h00;
            bclk_r    <= 1'b0;
            frame_r   <= 1'b0;
            fr_prev_r <= channel_frame_clock_in;  // follows pin, no false edge
        end
        else
        begin
            div_r     <= div_nxt;
            slot_r    <= slot_nxt;
            bclk_r    <= bclk_nxt;
            frame_r   <= frame_nxt;
            fr_prev_r <= channel_frame_clock_in;
        end
    end

    // ************************************************
    // start-up sequencer
    // ************************************************
    adc_seq_pkg::seq_state_type state_r;
    adc_seq_pkg::seq_state_type state_nxt;
    logic [1:0]  rel_r;      // reset release synchroniser
    logic [15:0] cal_r;      // calibration frame count
    logic [15:0] cal_nxt;
    logic [7:0]  fill_r;     // words since sampling began
    logic [7:0]  fill_nxt;
    logic        wclk_ok;    // word clock condition for the gate
    logic        filled;

    // RQ11 word clock must be high
    assign wclk_ok = !word_clock_in_mode || word_clock_in;
    assign running = (state_r == adc_seq_pkg::ST_CAL) ||
                     (state_r == adc_seq_pkg::ST_RUN);
    assign filled  = (fill_r == 8'(DELAY_WORDS));
    assign calibrating = (state_r == adc_seq_pkg::ST_CAL);
    assign sampling    = (state_r == adc_seq_pkg::ST_RUN);

    // state and counter next values
    always_comb
    begin
        state_nxt = state_r;
        cal_nxt   = cal_r;
        fill_nxt  = fill_r;
        case (state_r)
            adc_seq_pkg::ST_RESET:
            begin
                // power-down ends on the first clock out of reset
                state_nxt = adc_seq_pkg::ST_SYNC;
            end
            adc_seq_pkg::ST_SYNC:
            begin
                // RQ9 fixed release count
                if (rel_r[1])
                    state_nxt = slave_mode ? adc_seq_pkg::ST_WAIT_FALL
                                           : adc_seq_pkg::ST_CAL;
            end
            adc_seq_pkg::ST_WAIT_FALL:
            begin
                // RQ10 wait first frame fall
                if (fr_fall && wclk_ok)
                    state_nxt = adc_seq_pkg::ST_WAIT_RISE;
            end
            adc_seq_pkg::ST_WAIT_RISE:
            begin
                // RQ13 calibration starts at rise
                if (fr_rise && wclk_ok)
                    state_nxt = adc_seq_pkg::ST_CAL;
            end
            adc_seq_pkg::ST_CAL:
            begin
                // RQ12 count calibration frames
                if (word_tick)
                begin
                    if (cal_r == 16'(CAL_FRAMES - 1))
                        state_nxt = adc_seq_pkg::ST_RUN;
                    else
                        cal_nxt = cal_r + 16'h0001;
                end
            end
            adc_seq_pkg::ST_RUN:
            begin
                // RQ1 pipeline fill delay
                if (word_tick && !filled)
                    fill_nxt = fill_r + 8'h01;
            end
            default:
            begin
                state_nxt = adc_seq_pkg::ST_RESET;
            end
        endcase
    end

    // RQ14 reset is power-down, restart calibrates
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= adc_seq_pkg::ST_RESET;
            cal_r   <= 16'h0000;
            fill_r  <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            cal_r   <= cal_nxt;
            fill_r  <= fill_nxt;
        end
    end

    // RQ18 synchronise reset release
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rel_r <= 2'h0;
        else
            rel_r <= {rel_r[0], 1'b1};
    end

    // ************************************************
    // level tag and output buffer
    // ************************************************
    logic [15:0] mag_l;      // left magnitude, saturated
    logic [15:0] mag_r;      // right magnitude, saturated
    logic [1:0]  level;      // tag code of the incoming pair
    logic [33:0] fifo_out;
    logic        fifo_valid;
    logic        pop;

    // absolute value; the most negative code saturates
    function automatic logic [15:0] magnitude(input logic [15:0] s);
        logic [15:0] m;
        m = s[15] ? (~s + 16'h0001) : s;
        return m[15] ? 16'h7fff : m;
    endfunction : magnitude

    assign mag_l = magnitude(sample_in_left);
    assign mag_r = magnitude(sample_in_right);

    // RQ16 four level codes
    always_comb
    begin
        if (over_fs_more)
            level = `LVL_OVER_MORE;
        else if (over_fs_near)
            level = `LVL_OVER_NEAR;
        else if (mag_l >= `NEAR_FS_THRESH || mag_r >= `NEAR_FS_THRESH)
            level = `LVL_UNDER_NEAR;
        else
            level = `LVL_UNDER_MORE;
    end

    // pop one word per frame once the pipeline is full
    assign pop = sampling && filled && word_tick;

    // RQ6 buffer cleared by reset
    sample_fifo #(
        .WIDTH (34),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (sample_in_valid && sampling),
        .in_ready  (sample_in_ready),
        .in_data   ({level, sample_in_left, sample_in_right}),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_out)
    );

    // ************************************************
    // serial frame output
    // ************************************************
    logic [63:0] shift_r;    // frame bits, msb leaves first
    logic [63:0] shift_nxt;
    logic [1:0]  tag_r;      // level tag bits, msb first
    logic [1:0]  tag_nxt;

    // frame load and shift next values
    always_comb
    begin
        shift_nxt = shift_r;
        tag_nxt   = tag_r;
        if (!running)
        begin
            shift_nxt = 64'h0;
            tag_nxt   = 2'h0;
        end
        else if (word_tick)
        begin
            // RQ17 left word first, msb first
            if (pop && fifo_valid)
                shift_nxt = {fifo_out[31:16], 16'h0000,
                             fifo_out[15:0], 16'h0000};
            else
                // underrun or still filling: send silence
                shift_nxt = 64'h0;
            // RQ15 tag refreshed every sample
            tag_nxt = (pop && fifo_valid) ? fifo_out[33:32]
                                          : `LVL_UNDER_MORE;
        end
        else if (modulator_tick)
        begin
            shift_nxt = {shift_r[62:0], 1'b0};
            tag_nxt   = {tag_r[0], 1'b0};
        end
    end

    // shift registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            shift_r <= 64'h0;
            tag_r   <= 2'h0;
        end
        else
        begin
            shift_r <= shift_nxt;
            tag_r   <= tag_nxt;
        end
    end

    // RQ7 outputs low in reset, bit clock idles
    assign serial_data_output  = shift_r[63];
    assign level_tag_output    = tag_r[1];
    assign channel_frame_clock = frame_r && !slave_mode;
    // polarity applied outside the register so reset rests correctly
    assign serial_bit_clock = bclk_r ^ bit_clock_edge_select;

    // ************************************************
    // checks
    // ************************************************
    logic [6:0] ticks_r;     // modulator ticks since last word tick

    always_ff @(posedge clk)
    begin
        if (!rst_b || word_tick)
            ticks_r <= 7'h00;
        else if (modulator_tick)
            ticks_r <= ticks_r + 7'h01;
    end

    sequence s_fall_seen;
        state_r == adc_seq_pkg::ST_WAIT_RISE;
    endsequence

    sequence s_rise_go;
        fr_rise && wclk_ok;
    endsequence

    a_reset_quiet: assert property (@(posedge clk) // RQ7
        !rst_b |=> !rst_b |-> (!serial_data_output && !level_tag_output &&
        !channel_frame_clock &&
        serial_bit_clock == bit_clock_edge_select))
        else $error("outputs not at rest in reset");

    a_div_six: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
        modulator_tick && ratio_384_sel && $stable(ratio_384_sel) |->
        ##6 (modulator_tick || !running))
        else $error("modulator tick spacing wrong in 384 mode");
    a_div_four: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
        modulator_tick && !ratio_384_sel && $stable(ratio_384_sel) |->
        ##4 (modulator_tick || !running))
        else $error("modulator tick spacing wrong in 256 mode");

    a_word_rate: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
        word_tick && !slave_mode && $past(running) |->
        ticks_r == 7'h3f)
        else $error("word period not 64 modulator bits");

    a_slave_hold: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
        state_r == adc_seq_pkg::ST_WAIT_FALL |->
        !channel_frame_clock && !serial_data_output && !modulator_tick)
        else $error("slave not static before frame edges");

    a_slave_start: assert property (@(posedge clk) disable iff (!rst_b) // RQ13
        s_fall_seen ##0 s_rise_go |=> calibrating && cal_r == 16'h0000)
        else $error("calibration did not start at first rise");

    a_cal_length: assert property (@(posedge clk) disable iff (!rst_b) // RQ12
        calibrating && word_tick && cal_r != 16'(CAL_FRAMES - 1) |=>
        calibrating)
        else $error("calibration ended early");

    a_release_sync: assert property (@(posedge clk) disable iff (!rst_b) // RQ18
        $rose(rel_r[0]) |-> !running ##1 !running)
        else $error("sequencer ran before release synchronised");

    a_fill_delay: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
        word_tick && sampling && fill_r != 8'(DELAY_WORDS) |->
        !pop ##1 fill_r == $past(fill_r) + 8'h01)
        else $error("word left before group delay");

    a_tag_refresh: assert property (@(posedge clk) disable iff (!rst_b) // RQ15
        word_tick && running && !(pop && fifo_valid) |=>
        tag_r == `LVL_UNDER_MORE)
        else $error("level tag held a stale value");

endmodule : audio_adc_control_sequencer

`default_nettype wire

// File: logic/sample_fifo.sv
// small synchronous fifo holding converted words
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // pointer widths need a power of two depth
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("sample_fifo: bad width or depth");
    end

    // ***************************
    // storage and pointers
    // ***************************
    logic [WIDTH-1:0] mem_r [DEPTH];  // word storage
    logic [AW:0]      wr_r;           // write pointer, wrap bit on top
    logic [AW:0]      rd_r;           // read pointer
    logic [AW:0]      wr_nxt;
    logic [AW:0]      rd_nxt;
    logic             push;
    logic             pop;

    // full and empty from the wrap bit
    assign in_ready  = !((wr_r[AW] != rd_r[AW]) &&
                         (wr_r[AW-1:0] == rd_r[AW-1:0]));
    assign out_valid = (wr_r != rd_r);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_r[AW-1:0]];

    // pointer next values
    always_comb
    begin
        wr_nxt = wr_r + (AW+1)'(push);
        rd_nxt = rd_r + (AW+1)'(pop);
    end

    // reset empties the buffer, storage kept as is
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // data storage, written only on push
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_r[AW-1:0]] <= in_data;
    end

    // no pop when empty, no push when full
    a_fifo_bounds: assert property (@(posedge clk) disable iff (!rst_b)
        (out_valid || !pop) && ((wr_r - rd_r) <= (AW+1)'(DEPTH)))
        else $error("fifo pointers out of range");

endmodule : sample_fifo

`default_nettype wire

// File: test/host_frame_model.sv
// serial audio host model driving frame and word clocks
`default_nettype none

module host_frame_model #(
    parameter int HALF = 128  // clocks per frame half
) (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic wc_high,
    output var  logic channel_frame_clock_in,
    output logic      word_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************
    // frame clock generator
    // ************************************
    int cnt = 0;  // clocks into the current half
    logic fc = 1'b1;  // frame level, stands high while idle

    // frame clock counted from the master clock
    // stopped clock holds level so a start can be withheld
    always @(negedge clk)
    begin
        if (run)
        begin
            if (cnt == HALF - 1)
            begin
                cnt <= 0;
                fc  <= ~fc;
            end
            else
                cnt <= cnt + 1;
        end
    end

    assign channel_frame_clock_in = fc;
    // word clock level set by the bench
    assign word_clock_in = wc_high;

endmodule : host_frame_model

`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the converter control sequencer
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************
    // signals
    // ************************************
    localparam int CAL = 8;  // short calibration for speed
    localparam int DLY = 3;  // short group delay for speed
    localparam logic [15:0] LW [8] = '{16'h1234, 16'h7300, 16'h8000,
        16'hffff, 16'h7215, 16'h0001, 16'h4000, 16'h0100};
    localparam logic [15:0] RW [8] = '{16'h0042, 16'h0100, 16'h2000,
        16'h8001, 16'h0003, 16'h5555, 16'h0007, 16'h7213};
    localparam logic [7:0] NR = 8'h4c;  // near-over flags per word
    localparam logic [7:0] MR = 8'h28;  // more-over flags per word
    localparam logic [1:0] TG [8] = '{2'h0, 2'h1, 2'h2, 2'h3,
        2'h1, 2'h3, 2'h2, 2'h0};
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ratio_384_sel = 1'b0;
    logic        slave_mode = 1'b0;
    logic        word_clock_in_mode = 1'b0;
    logic        bit_clock_edge_select = 1'b0;
    logic        channel_frame_clock_in;
    logic        word_clock_in;
    logic        sample_in_valid = 1'b0;
    logic        sample_in_ready;
    logic [15:0] sample_in_left = 16'h0;
    logic [15:0] sample_in_right = 16'h0;
    logic        over_fs_near = 1'b0;
    logic        over_fs_more = 1'b0;
    logic        modulator_tick, serial_bit_clock, channel_frame_clock;
    logic        serial_data_output, level_tag_output;
    logic        calibrating, sampling;
    logic        run = 1'b0;     // host frame clock enable
    logic        wc = 1'b0;      // host word clock level
    logic        fc_q, fi_q;     // last falling-edge frame levels
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;        // hang guard

    // ************************************
    // instances and clock
    // ************************************
    audio_adc_control_sequencer #(.CAL_FRAMES(CAL), .DELAY_WORDS(DLY),
        .FIFO_DEPTH(8)) i_dut (.clk, .rst_b, .ratio_384_sel,
        .slave_mode, .word_clock_in_mode, .bit_clock_edge_select,
        .channel_frame_clock_in, .word_clock_in, .sample_in_valid,
        .sample_in_ready, .sample_in_left, .sample_in_right,
        .over_fs_near, .over_fs_more, .modulator_tick,
        .serial_bit_clock, .channel_frame_clock, .serial_data_output,
        .level_tag_output, .calibrating, .sampling);
    host_frame_model #(.HALF(128)) i_host (.clk, .run, .wc_high(wc),
        .channel_frame_clock_in, .word_clock_in);

    always #5 clk = ~clk;

    // edge history for rise detection
    always @(negedge clk)
    begin
        fc_q <= channel_frame_clock;
        fi_q <= channel_frame_clock_in;
    end

    // whole run needs about 20k cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ************************************
    // helpers
    // ************************************
    task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    // power-down with mode pins set, then release
    task automatic start(input logic r, input logic s, input logic e);
        @(negedge clk);
        rst_b = 1'b0;
        ratio_384_sel = r;
        slave_mode = s;
        word_clock_in_mode = s;
        bit_clock_edge_select = e;
        repeat (10) @(negedge clk);
        chk({modulator_tick, channel_frame_clock, serial_data_output,
            level_tag_output, serial_bit_clock, sample_in_ready},
            {4'h0, e, 1'b1});
        chk({calibrating, sampling}, 2'h0);
        rst_b = 1'b1;
    endtask : start

    // master start-up, timing the calibration span
    task automatic run_up(input logic r);
        int n;
        int dv;
        dv = r ? 6 : 4;
        start(r, 1'b0, r);
        repeat (2) @(negedge clk);
        chk(calibrating, 1'b0);
        @(negedge clk);
        chk(calibrating, 1'b1);
        @(negedge clk);
        chk(calibrating, 1'b1);
        n = 4;
        while (!sampling && n < 9000)
        begin
            @(negedge clk);
            n++;
        end
        chk((n + 32 * dv) / (64 * dv), CAL);
        // tick spacing gives the divide ratio
        n = 0;
        while (!modulator_tick && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        n = 1;
        while (!modulator_tick && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        chk(n, dv);
    endtask : run_up

    // capture one 64-slot frame at the bit ticks
    task automatic get_frame(output logic [63:0] d, output logic [1:0] t);
        logic [63:0] f;
        int n;
        n = 0;
        while (!(channel_frame_clock && !fc_q) && n < 900)
        begin
            @(negedge clk);
            n++;
        end
        for (int i = 63; i >= 0; i--)
        begin
            n = 0;
            while (!modulator_tick && n < 10)
            begin
                @(negedge clk);
                n++;
            end
            d[i] = serial_data_output;
            f[i] = channel_frame_clock;
            if (i > 61)
                t[i-62] = level_tag_output;
            @(negedge clk);
        end
        chk(f, 64'hffffffff00000000);
    endtask : get_frame

    // ************************************
    // scenarios
    // ************************************
    // fill the buffer until refused, then drain frame by frame
    task automatic t_stream;
        logic [63:0] d;
        logic [1:0] t;
        int z;
        run_up(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            chk(sample_in_ready, 1'b1);
            sample_in_valid = 1'b1;
            sample_in_left = LW[i];
            sample_in_right = RW[i];
            over_fs_near = NR[i];
            over_fs_more = MR[i];
            @(negedge clk);
        end
        chk(sample_in_ready, 1'b0);
        // a word offered while full must vanish
        sample_in_left = 16'h0dea;
        over_fs_more = 1'b1;
        @(negedge clk);
        sample_in_valid = 1'b0;
        over_fs_near = 1'b0;
        over_fs_more = 1'b0;
        z = 0;
        get_frame(d, t);
        while (d == 64'h0 && z < 10)
        begin
            z++;
            get_frame(d, t);
        end
        chk(z inside {DLY - 1, DLY}, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            if (i > 0)
                get_frame(d, t);
            chk(d, {LW[i], 16'h0, RW[i], 16'h0});
            chk(t, TG[i]);
        end
        get_frame(d, t);
        chk({d, t}, 66'h0);
        chk(sample_in_ready, 1'b1);
    endtask : t_stream

    // reset in mid-run drops buffered words
    task automatic t_clear;
        logic [63:0] d;
        logic [1:0] t;
        run_up(1'b1);
        sample_in_valid = 1'b1;
        sample_in_left = LW[1];
        repeat (2) @(negedge clk);
        sample_in_valid = 1'b0;
        run_up(1'b1);
        repeat (DLY + 2)
        begin
            get_frame(d, t);
            chk({d, t}, 66'h0);
        end
    endtask : t_clear

    // slave start gated on host frame and word clocks
    task automatic t_slave;
        int n;
        start(1'b0, 1'b1, 1'b0);
        repeat (300) @(negedge clk);
        chk({calibrating, sampling, channel_frame_clock,
            serial_data_output, level_tag_output}, 5'h0);
        run = 1'b1;
        repeat (300) @(negedge clk);
        chk(calibrating, 1'b0);
        wc = 1'b1;
        n = 0;
        repeat (5000)
        begin
            @(negedge clk);
            if (channel_frame_clock_in && !fi_q && calibrating && !sampling)
                n++;
        end
        chk(sampling, 1'b1);
        chk(n, CAL);
        run = 1'b0;
    endtask : t_slave

    // ************************************
    // sequence and verdict
    // ************************************
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial
    begin
        t_stream();
        t_clear();
        t_slave();
        wrap_up();
    end

endmodule : testbench

`default_nettype wire
